// file: hdl/plc_consts.svh
// constants for the phy link control and led block
// assumes a 100 MHz core clock and a synchronous active-high reset
// Notes on behaviour
// - resolve highest common speed/duplex in priority order
// - no partner pages: mode from sensed line signal
// - gigabit only via negotiation, roles resolved first
// - negotiation on after reset, bit 12 controls
// - negotiation off: speed bits 6/13, duplex 8
// - speed change on the fly drops link
// - duplex/pause changes need restart or relink
// - completion updates link status and partner registers
// - next page exchange agrees energy efficient support
// - remote loopback returns line data to partner, full duplex only
// - led mode bit: 1 single, 0 tri-color
// - both led outputs active low
// - tri gigabit: link pin shows, activity high
// - tri 100: activity pin shows, link high
// - tri 10: both pins together
`ifndef PLC_CONSTS_SVH
`define PLC_CONSTS_SVH
`define PLC_CTL_SPEED_LSB 6
`define PLC_CTL_DUPLEX 8
`define PLC_CTL_RESTART 9
`define PLC_CTL_AN_EN 12
`define PLC_CTL_SPEED_MSB 13
`define PLC_CTL_RESET_VAL 16'h1140
// ability vector bit positions
`define PLC_AB_10H 0
`define PLC_AB_10F 1
`define PLC_AB_100H 2
`define PLC_AB_100F 3
`define PLC_AB_1GH 4
`define PLC_AB_1GF 5
`define PLC_LED_MODE_BIT 4
`define PLC_CLK_HZ 100000000
`define PLC_BLINK_MS 40
`define PLC_BLINK_CYC ((`PLC_CLK_HZ / 1000) * `PLC_BLINK_MS)
`define PLC_BLINK_W 22
`endif

// file: hdl/plc_pkg.sv
// types shared by the phy link control and led files
// assumes the constants header is included by users
package plc_pkg;
   typedef enum logic [1:0] {PLC_SPD_10, PLC_SPD_100, PLC_SPD_1000,
      PLC_SPD_NONE} plc_speed_t;
endpackage

// file: hdl/plc_blinker.sv
// activity blink generator for one port
// assumes single pulse activity events in the core clock domain
`timescale 1ns/10ps
`include "plc_consts.svh"
module plc_blinker
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_activity,
   output logic o_active,
   output logic o_phase
);
   logic [`PLC_BLINK_W-1:0] cnt_reg, cnt_next;
   logic pend_reg, pend_next;
   logic act_reg, act_next;
   logic ph_reg, ph_next;
   always_comb
   begin
      cnt_next = cnt_reg;
      pend_next = pend_reg | i_activity;
      act_next = act_reg;
      ph_next = ph_reg;
      // each half period is a full tick so short packets still blink
      if (cnt_reg == `PLC_BLINK_W'(`PLC_BLINK_CYC - 1))
      begin
         cnt_next = '0;
         if (act_reg && ph_reg)
         begin
            ph_next = 1'b0;
         end
         else if (pend_reg)
         begin
            act_next = 1'b1;
            ph_next = 1'b1;
            pend_next = i_activity;
         end
         else
         begin
            act_next = 1'b0;
         end
      end
      else
      begin
         cnt_next = cnt_reg + `PLC_BLINK_W'(1);
      end
   end
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         cnt_reg <= '0;
         pend_reg <= 1'b0;
         act_reg <= 1'b0;
         ph_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         pend_reg <= pend_next;
         act_reg <= act_next;
         ph_reg <= ph_next;
      end
   end
   assign o_active = act_reg;
   assign o_phase = ph_reg;
endmodule

// file: hdl/plc_resolver.sv
// highest common mode resolution from two ability vectors
// assumes vectors laid out by the ability bit constants
`timescale 1ns/10ps
`include "plc_consts.svh"
module plc_resolver
(
   input wire logic [5:0] i_local_ab,
   input wire logic [5:0] i_partner_ab,
   output plc_pkg::plc_speed_t o_speed,
   output logic o_full,
   output logic o_found
);
   import plc_pkg::*;
   logic [5:0] common;
   always_comb
   begin
      common = i_local_ab & i_partner_ab;
      o_found = 1'b1;
      o_speed = PLC_SPD_NONE;
      o_full = 1'b0;
      // fixed priority from fastest full down to 10 half
      if (common[`PLC_AB_1GF])
      begin
         o_speed = PLC_SPD_1000;
         o_full = 1'b1;
      end
      else if (common[`PLC_AB_1GH])
         o_speed = PLC_SPD_1000;
      else if (common[`PLC_AB_100F])
      begin
         o_speed = PLC_SPD_100;
         o_full = 1'b1;
      end
      else if (common[`PLC_AB_100H])
         o_speed = PLC_SPD_100;
      else if (common[`PLC_AB_10F])
      begin
         o_speed = PLC_SPD_10;
         o_full = 1'b1;
      end
      else if (common[`PLC_AB_10H])
         o_speed = PLC_SPD_10;
      else
         o_found = 1'b0;
   end
endmodule

// file: hdl/plc_top.sv
// per-port link control, remote loopback and led driver
// assumes line-side events from the analog front end, one cycle pulses,
// and control register fields presented as plain ports
`timescale 1ns/10ps
`include "plc_consts.svh"
module plc_top
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic [15:0] i_ctl_data,
   input wire logic i_ctl_we,
   input wire logic [5:0] i_adv_ab,
   input wire logic i_adv_pause,
   input wire logic i_adv_eee,
   input wire logic i_led_mode_data,
   input wire logic i_led_mode_we,
   input wire logic i_remote_lb_en,
   input wire logic i_pages_rx,
   input wire logic [5:0] i_partner_ab,
   input wire logic i_partner_pause,
   input wire logic i_partner_eee,
   input wire logic i_ms_resolved,
   input wire logic i_ms_fault,
   input wire logic i_ms_is_master,
   input wire logic i_pd_valid,
   input wire logic i_pd_is_100,
   input wire logic i_line_ok,
   input wire logic [7:0] i_rx_data,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_mac_tx_data,
   input wire logic i_mac_tx_valid,
   output logic [7:0] o_tx_data,
   output logic o_tx_valid,
   output logic [7:0] o_mac_rx_data,
   output logic o_mac_rx_valid,
   output logic o_link_up,
   output logic o_an_complete,
   output logic o_an_restart_busy,
   output logic [1:0] o_speed,
   output logic o_full_duplex,
   output logic o_pause_on,
   output logic o_eee_on,
   output logic o_master,
   output logic o_parallel_detect,
   output logic [5:0] o_lp_ability,
   output logic o_lp_pause,
   output logic o_lp_an_able,
   output logic o_gig_lp_full,
   output logic o_gig_lp_half,
   output logic o_ms_fault,
   output logic o_led_single,
   output logic o_link_indicator_out_n,
   output logic o_activity_indicator_out_n
);
   import plc_pkg::*;
   typedef enum logic [1:0] {PLC_ST_DOWN, PLC_ST_NEG, PLC_ST_UP}
      plc_state_t;

   function automatic plc_speed_t plc_forced_speed(input logic [15:0] c);
      unique case ({c[`PLC_CTL_SPEED_MSB], c[`PLC_CTL_SPEED_LSB]})
         2'b00: plc_forced_speed = PLC_SPD_10;
         2'b10: plc_forced_speed = PLC_SPD_100;
         2'b01: plc_forced_speed = PLC_SPD_1000;
         default: plc_forced_speed = PLC_SPD_NONE;
      endcase
   endfunction

   plc_state_t st_reg, st_next;
   logic [15:0] ctl_reg, ctl_next;
   logic rst_pend_reg, rst_pend_next;
   plc_speed_t spd_reg, spd_next;
   logic full_reg, full_next;
   logic pause_reg, pause_next;
   logic eee_reg, eee_next;
   logic mst_reg, mst_next;
   logic pd_reg, pd_next;
   logic done_reg, done_next;
   logic [5:0] lpab_reg, lpab_next;
   logic lpp_reg, lpp_next;
   logic lpan_reg, lpan_next;
   logic msf_reg, msf_next;
   logic ledm_reg, ledm_next;
   logic [7:0] txd_reg, txd_next;
   logic txv_reg, txv_next;
   logic [7:0] mrd_reg, mrd_next;
   logic mrv_reg, mrv_next;
   logic lnk_n_reg, lnk_n_next;
   logic act_n_reg, act_n_next;
   plc_speed_t res_spd;
   logic res_full, res_found;
   logic blink_act, blink_ph;
   logic an_en;
   logic speed_chg;

   plc_resolver u_res
   (
      .i_local_ab(i_adv_ab),
      .i_partner_ab(i_partner_ab),
      .o_speed(res_spd),
      .o_full(res_full),
      .o_found(res_found)
   );

   plc_blinker u_blink
   (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_activity(i_rx_valid | o_tx_valid),
      .o_active(blink_act),
      .o_phase(blink_ph)
   );

   assign an_en = ctl_reg[`PLC_CTL_AN_EN];
   // a speed write while running restarts link bring-up
   assign speed_chg = i_ctl_we &&
      (i_ctl_data[`PLC_CTL_SPEED_MSB] != ctl_reg[`PLC_CTL_SPEED_MSB] ||
       i_ctl_data[`PLC_CTL_SPEED_LSB] != ctl_reg[`PLC_CTL_SPEED_LSB] ||
       i_ctl_data[`PLC_CTL_AN_EN] != ctl_reg[`PLC_CTL_AN_EN]);

   always_comb
   begin
      st_next = st_reg;
      ctl_next = ctl_reg;
      rst_pend_next = rst_pend_reg;
      spd_next = spd_reg;
      full_next = full_reg;
      pause_next = pause_reg;
      eee_next = eee_reg;
      mst_next = mst_reg;
      pd_next = pd_reg;
      done_next = done_reg;
      lpab_next = lpab_reg;
      lpp_next = lpp_reg;
      lpan_next = lpan_reg;
      msf_next = msf_reg;
      if (i_ctl_we)
      begin
         ctl_next = i_ctl_data;
         // restart bit self clears at once, rst_pend_reg holds the request
         ctl_next[`PLC_CTL_RESTART] = 1'b0;
         if (i_ctl_data[`PLC_CTL_RESTART])
            rst_pend_next = 1'b1;
      end
      unique case (st_reg)
         PLC_ST_DOWN:
         begin
            done_next = 1'b0;
            rst_pend_next = 1'b0;
            if (i_line_ok)
               st_next = PLC_ST_NEG;
         end
         PLC_ST_NEG:
         begin
            if (!i_line_ok)
               st_next = PLC_ST_DOWN;
            else if (!an_en)
            begin
               // forced mode from control bits
               if (plc_forced_speed(ctl_reg) != PLC_SPD_NONE &&
                   plc_forced_speed(ctl_reg) != PLC_SPD_1000)
               begin
                  spd_next = plc_forced_speed(ctl_reg);
                  full_next = ctl_reg[`PLC_CTL_DUPLEX];
                  pause_next = 1'b0;
                  eee_next = 1'b0;
                  pd_next = 1'b0;
                  st_next = PLC_ST_UP;
               end
            end
            else if (i_pages_rx && res_found)
            begin
               // gigabit waits for the role outcome
               if (res_spd != PLC_SPD_1000 || i_ms_resolved)
               begin
                  spd_next = res_spd;
                  full_next = res_full;
                  pause_next = res_full && i_adv_pause && i_partner_pause;
                  // energy efficient only if both pages agree
                  eee_next = i_adv_eee && i_partner_eee;
                  mst_next = i_ms_is_master;
                  pd_next = 1'b0;
                  // partner copies appear with completion
                  done_next = 1'b1;
                  lpab_next = i_partner_ab;
                  lpp_next = i_partner_pause;
                  lpan_next = 1'b1;
                  msf_next = 1'b0;
                  st_next = PLC_ST_UP;
               end
               else if (i_ms_fault)
                  msf_next = 1'b1;
            end
            else if (i_pd_valid && !i_pages_rx)
            begin
               // parallel detect is never gigabit, half duplex
               spd_next = i_pd_is_100 ? PLC_SPD_100 : PLC_SPD_10;
               full_next = 1'b0;
               pause_next = 1'b0;
               eee_next = 1'b0;
               pd_next = 1'b1;
               done_next = 1'b1;
               lpan_next = 1'b0;
               lpab_next = '0;
               st_next = PLC_ST_UP;
            end
         end
         PLC_ST_UP:
         begin
            // duplex/pause edits are held until restart or relink
            if (!i_line_ok || speed_chg || rst_pend_reg)
            begin
               st_next = speed_chg || rst_pend_reg ?
                  PLC_ST_NEG : PLC_ST_DOWN;
               rst_pend_next = 1'b0;
               done_next = 1'b0;
               spd_next = PLC_SPD_NONE;
            end
         end
         default: st_next = PLC_ST_DOWN;
      endcase
   end

   always_comb
   begin
      // loopback bypasses the mac path, full duplex only
      if (i_remote_lb_en && full_reg && st_reg == PLC_ST_UP)
      begin
         txd_next = i_rx_data;
         txv_next = i_rx_valid;
         mrv_next = 1'b0;
      end
      else
      begin
         txd_next = i_mac_tx_data;
         txv_next = i_mac_tx_valid;
         mrv_next = i_rx_valid;
      end
      mrd_next = i_rx_data;
      ledm_next = i_led_mode_we ? i_led_mode_data : ledm_reg;
   end

   always_comb
   begin
      // pins are active low, so 0 lights the led
      lnk_n_next = 1'b1;
      act_n_next = 1'b1;
      if (st_reg == PLC_ST_UP)
      begin
         if (ledm_reg)
         begin
            lnk_n_next = 1'b0;
            act_n_next = ~(blink_act & blink_ph);
         end
         else
         begin
            unique case (spd_reg)
               PLC_SPD_1000: lnk_n_next = blink_act & blink_ph;
               PLC_SPD_100: act_n_next = blink_act & blink_ph;
               PLC_SPD_10:
               begin
                  lnk_n_next = blink_act & blink_ph;
                  act_n_next = blink_act & blink_ph;
               end
               default:
               begin
                  lnk_n_next = 1'b1;
                  act_n_next = 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         st_reg <= PLC_ST_DOWN;
         ctl_reg <= `PLC_CTL_RESET_VAL;
         rst_pend_reg <= 1'b0;
         spd_reg <= PLC_SPD_NONE;
         full_reg <= 1'b0;
         pause_reg <= 1'b0;
         eee_reg <= 1'b0;
         mst_reg <= 1'b0;
         pd_reg <= 1'b0;
         done_reg <= 1'b0;
         lpab_reg <= '0;
         lpp_reg <= 1'b0;
         lpan_reg <= 1'b0;
         msf_reg <= 1'b0;
         ledm_reg <= 1'b0;
         txd_reg <= '0;
         txv_reg <= 1'b0;
         mrd_reg <= '0;
         mrv_reg <= 1'b0;
         lnk_n_reg <= 1'b1;
         act_n_reg <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
         ctl_reg <= ctl_next;
         rst_pend_reg <= rst_pend_next;
         spd_reg <= spd_next;
         full_reg <= full_next;
         pause_reg <= pause_next;
         eee_reg <= eee_next;
         mst_reg <= mst_next;
         pd_reg <= pd_next;
         done_reg <= done_next;
         lpab_reg <= lpab_next;
         lpp_reg <= lpp_next;
         lpan_reg <= lpan_next;
         msf_reg <= msf_next;
         ledm_reg <= ledm_next;
         txd_reg <= txd_next;
         txv_reg <= txv_next;
         mrd_reg <= mrd_next;
         mrv_reg <= mrv_next;
         lnk_n_reg <= lnk_n_next;
         act_n_reg <= act_n_next;
      end
   end

   assign o_tx_data = txd_reg;
   assign o_tx_valid = txv_reg;
   assign o_mac_rx_data = mrd_reg;
   assign o_mac_rx_valid = mrv_reg;
   assign o_link_up = (st_reg == PLC_ST_UP);
   assign o_an_complete = done_reg;
   assign o_an_restart_busy = rst_pend_reg;
   assign o_speed = spd_reg;
   assign o_full_duplex = full_reg;
   assign o_pause_on = pause_reg;
   assign o_eee_on = eee_reg;
   assign o_master = mst_reg;
   assign o_parallel_detect = pd_reg;
   assign o_lp_ability = lpab_reg;
   assign o_lp_pause = lpp_reg;
   assign o_lp_an_able = lpan_reg;
   assign o_gig_lp_full = lpab_reg[`PLC_AB_1GF];
   assign o_gig_lp_half = lpab_reg[`PLC_AB_1GH];
   assign o_ms_fault = msf_reg;
   assign o_led_single = ledm_reg;
   assign o_link_indicator_out_n = lnk_n_reg;
   assign o_activity_indicator_out_n = act_n_reg;
endmodule

// file: tb/plc_partner.sv
// link partner phy model: pages, roles, fixed signal and line bytes
// assumes the bench changes its wishes just after a clock edge
`timescale 1ns/10ps
module plc_partner
(
   input wire logic i_core_clk,
   input wire logic i_connect,
   input wire logic i_an,
   input wire logic [5:0] i_ab,
   input wire logic i_is_100,
   input wire logic i_burst,
   output logic o_line_ok,
   output logic o_pages_rx,
   output logic [5:0] o_ab,
   output logic o_pause,
   output logic o_master,
   output logic o_ms_resolved,
   output logic o_pd_valid,
   output logic o_pd_is_100,
   output logic [7:0] o_rx_data,
   output logic o_rx_valid
);
   logic [1:0] ms_cnt;
   initial
   begin
      {o_line_ok, o_pages_rx, o_pause, o_master, o_ms_resolved} = 5'h00;
      {o_pd_valid, o_pd_is_100, o_rx_valid} = 3'h0;
      o_ab = 6'h00;
      o_rx_data = 8'h00;
      ms_cnt = 2'h0;
   end
   always @(posedge i_core_clk)
   begin
      o_line_ok <= i_connect;
      o_pages_rx <= i_connect && i_an;
      // no pages on the wire: ability lines carry junk
      o_ab <= i_an ? i_ab : ~o_ab;
      o_pause <= i_connect && i_an;
      o_master <= 1'h0;
      // roles settle slowly, a few cycles after pages
      ms_cnt <= (i_connect && i_an) ? ms_cnt + {1'h0, ms_cnt != 2'h3} : 2'h0;
      o_ms_resolved <= ms_cnt == 2'h3;
      o_pd_valid <= i_connect && !i_an;
      o_pd_is_100 <= i_is_100;
      o_rx_data <= o_rx_data + 8'h01;
      o_rx_valid <= i_burst && i_connect;
   end
endmodule

// file: tb/plc_properties.sv
// timing relations at the ports of the link control and led block
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/10ps
module plc_properties
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic [15:0] i_ctl_data,
   input wire logic i_ctl_we,
   input wire logic i_led_mode_data,
   input wire logic i_led_mode_we,
   input wire logic i_remote_lb_en,
   input wire logic [7:0] i_rx_data,
   input wire logic i_rx_valid,
   input wire logic [7:0] o_tx_data,
   input wire logic o_tx_valid,
   input wire logic o_mac_rx_valid,
   input wire logic o_link_up,
   input wire logic o_an_complete,
   input wire logic [1:0] o_speed,
   input wire logic o_full_duplex,
   input wire logic o_led_single,
   input wire logic o_link_indicator_out_n,
   input wire logic o_activity_indicator_out_n
);
   logic prev_link_reg, prev_single_reg, steady, lb;
   logic [1:0] prev_speed_reg;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   always_ff @(posedge i_core_clk)
   begin
      prev_link_reg <= o_link_up;
      prev_single_reg <= o_led_single;
      prev_speed_reg <= o_speed;
   end
   // leds lag link state by one cycle, so judge only settled states
   assign steady = o_link_up && prev_link_reg && o_speed == prev_speed_reg
      && o_led_single == prev_single_reg;
   assign lb = o_link_up && o_full_duplex && i_remote_lb_en && i_rx_valid;
   a_dark_no_link:
      assert property ((!o_link_up)[*2] |-> o_link_indicator_out_n
         && o_activity_indicator_out_n) else $error("led lit without link");
   a_single_link_lit:
      assert property (steady && o_led_single |-> !o_link_indicator_out_n)
         else $error("single mode link led dark");
   a_tri_gig_act:
      assert property (steady && !o_led_single && o_speed == 2'h2
         |-> o_activity_indicator_out_n) else $error("gig activity lit");
   a_tri_fast_link:
      assert property (steady && !o_led_single && o_speed == 2'h1
         |-> o_link_indicator_out_n) else $error("100 link led lit");
   a_tri_ten_pair:
      assert property (steady && !o_led_single && o_speed == 2'h0
         |-> o_link_indicator_out_n == o_activity_indicator_out_n)
         else $error("10 led pins differ");
   a_loop_echo:
      assert property (lb |=> o_tx_valid && o_tx_data == $past(i_rx_data))
         else $error("loopback byte not returned");
   a_loop_no_mac:
      assert property (lb |=> !o_mac_rx_valid) else $error("loop hit mac");
   a_restart_drop:
      assert property (o_link_up && i_ctl_we && i_ctl_data[9]
         |-> ##[1:3] !o_link_up) else $error("restart kept link");
   a_mode_write:
      assert property (i_led_mode_we |=> o_led_single == $past(i_led_mode_data))
         else $error("led mode not stored");
   a_gig_via_an:
      assert property (o_link_up && o_speed == 2'h2 |-> o_an_complete)
         else $error("gig link without negotiation");
   c_gig_up: cover property (steady && o_speed == 2'h2);
   c_loop: cover property (lb);
   c_restart: cover property (o_link_up && i_ctl_we && i_ctl_data[9]);
endmodule
bind plc_top plc_properties u_plc_properties (.i_core_clk, .i_reset,
   .i_ctl_data, .i_ctl_we, .i_led_mode_data, .i_led_mode_we,
   .i_remote_lb_en, .i_rx_data, .i_rx_valid, .o_tx_data, .o_tx_valid,
   .o_mac_rx_valid, .o_link_up, .o_an_complete, .o_speed, .o_full_duplex,
   .o_led_single, .o_link_indicator_out_n, .o_activity_indicator_out_n);

// file: tb/tb_phy_link_control_and_led.sv
// self-checking bench for the per-port link control and led block
// assumes the partner model and the checker are compiled beforehand
`timescale 1ns/10ps
module tb_phy_link_control_and_led;
   logic i_core_clk, i_reset, i_ctl_we, i_led_mode_data, i_led_mode_we;
   logic i_remote_lb_en, i_adv_pause, cn, pan, p100, burst;
   logic [15:0] i_ctl_data;
   logic [5:0] i_adv_ab, pab, i_partner_ab, o_lp_ability;
   logic i_line_ok, i_pages_rx, i_ms_resolved, i_pd_valid, i_pd_is_100;
   logic i_rx_valid, i_partner_pause, i_ms_is_master, o_tx_valid;
   logic [7:0] i_rx_data, o_tx_data;
   logic o_mac_rx_valid, o_link_up, o_an_complete, o_full_duplex;
   logic o_parallel_detect, o_led_single, o_link_indicator_out_n;
   logic o_activity_indicator_out_n, o_an_restart_busy;
   logic [1:0] o_speed;
   int n_errors = 0;
   int compares = 0;
   plc_top u_plc_top (.i_adv_eee(1'h0), .i_partner_eee(1'h0),
      .i_ms_fault(1'h0), .i_mac_tx_data(8'h00), .i_mac_tx_valid(1'h0),
      .o_mac_rx_data(), .o_pause_on(), .o_eee_on(), .o_master(),
      .o_lp_pause(), .o_lp_an_able(), .o_gig_lp_full(), .o_gig_lp_half(),
      .o_ms_fault(), .*);
   plc_partner u_plc_partner (.i_core_clk(i_core_clk), .i_connect(cn),
      .i_an(pan), .i_ab(pab), .i_is_100(p100), .i_burst(burst),
      .o_line_ok(i_line_ok), .o_pages_rx(i_pages_rx), .o_ab(i_partner_ab),
      .o_pause(i_partner_pause), .o_master(i_ms_is_master),
      .o_ms_resolved(i_ms_resolved), .o_pd_valid(i_pd_valid),
      .o_pd_is_100(i_pd_is_100), .o_rx_data(i_rx_data),
      .o_rx_valid(i_rx_valid));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wait_link(input logic v);
      for (int i = 0; i < 60 && o_link_up !== v; i++) @(negedge i_core_clk);
      chk("link", {7'h0, v}, {7'h0, o_link_up});
   endtask
   task automatic wr_ctl(input logic [15:0] v);
      @(posedge i_core_clk);
      i_ctl_data <= v;
      i_ctl_we <= 1'h1;
      @(posedge i_core_clk);
      i_ctl_we <= 1'h0;
   endtask
   task automatic link(input logic [5:0] ab, input logic an, input logic f);
      @(posedge i_core_clk);
      cn <= 1'h0;
      repeat (4) @(posedge i_core_clk);
      {pab, pan, p100, cn} <= {ab, an, f, 1'h1};
      wait_link(1'h1);
      repeat (3) @(negedge i_core_clk);
   endtask
   // idle leds per speed and led mode, pins {link, activity}
   task automatic st(input logic [1:0] sp, input logic fd);
      logic [1:0] led;
      led = o_led_single ? 2'h1 : (sp == 2'h2 ? 2'h1 : {sp == 2'h1, 1'h0});
      chk("speed", {6'h0, sp}, {6'h0, o_speed});
      chk("duplex", {7'h0, fd}, {7'h0, o_full_duplex});
      chk("leds", {6'h0, led},
         {6'h0, o_link_indicator_out_n, o_activity_indicator_out_n});
   endtask
   task automatic t_resolve;
      logic [5:0] ab [6] = '{6'h3A, 6'h14, 6'h0E, 6'h06, 6'h03, 6'h01};
      logic [1:0] sp [6] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
      for (int i = 0; i < 6; i++)
      begin
         link(ab[i], 1'h1, 1'h0);
         st(sp[i], i % 2 == 0);
         chk("lp", {2'h0, ab[i]}, {2'h0, o_lp_ability});
         chk("an done", 8'h01, {7'h0, o_an_complete});
      end
      $display("test resolve done");
   endtask
   task automatic t_parallel;
      link(6'h0C, 1'h0, 1'h1);
      st(2'h1, 1'h0);
      chk("pd", 8'h01, {7'h0, o_parallel_detect});
      link(6'h0C, 1'h0, 1'h0);
      st(2'h0, 1'h0);
      $display("test parallel done");
   endtask
   task automatic t_forced;
      link(6'h3F, 1'h1, 1'h0);
      wr_ctl(16'h0100);
      wait_link(1'h0);
      wait_link(1'h1);
      repeat (3) @(negedge i_core_clk);
      st(2'h0, 1'h1);
      wr_ctl(16'h0140);
      repeat (60) @(negedge i_core_clk);
      chk("forced gig", 8'h00, {7'h0, o_link_up});
      wr_ctl(16'h1140);
      wait_link(1'h1);
      repeat (3) @(negedge i_core_clk);
      st(2'h2, 1'h1);
      $display("test forced done");
   endtask
   task automatic t_restart;
      link(6'h3F, 1'h1, 1'h0);
      @(posedge i_core_clk);
      i_adv_ab <= 6'h1F;
      repeat (10) @(negedge i_core_clk);
      st(2'h2, 1'h1);
      wr_ctl(16'h1340);
      wait_link(1'h0);
      wait_link(1'h1);
      repeat (3) @(negedge i_core_clk);
      st(2'h2, 1'h0);
      @(posedge i_core_clk);
      i_adv_ab <= 6'h3F;
      $display("test restart done");
   endtask
   // one remote loopback bring-up: local abilities, control word, speed
   task automatic t_loop(input logic [5:0] adv, input logic [15:0] w,
      input logic [1:0] sp);
      logic [7:0] e;
      @(posedge i_core_clk);
      i_adv_ab <= adv;
      link(6'h3F, 1'h1, 1'h0);
      @(posedge i_core_clk);
      i_remote_lb_en <= 1'h1;
      wr_ctl(w);
      wait_link(1'h0);
      wait_link(1'h1);
      repeat (3) @(negedge i_core_clk);
      st(sp, 1'h1);
      @(posedge i_core_clk);
      burst <= 1'h1;
      repeat (3) @(negedge i_core_clk);
      for (int i = 0; i < 8; i++)
      begin
         e = i_rx_data;
         @(negedge i_core_clk);
         chk("loop data", e, o_tx_data);
         chk("loop valid", 8'h01, {7'h0, o_tx_valid});
         chk("mac valid", 8'h00, {7'h0, o_mac_rx_valid});
      end
      @(posedge i_core_clk);
      burst <= 1'h0;
      i_remote_lb_en <= 1'h0;
      i_adv_ab <= 6'h3F;
      $display("test loop done");
   endtask
   task automatic t_single;
      @(posedge i_core_clk);
      {i_led_mode_data, i_led_mode_we} <= 2'h3;
      @(posedge i_core_clk);
      i_led_mode_we <= 1'h0;
      link(6'h3F, 1'h1, 1'h0);
      chk("mode", 8'h01, {7'h0, o_led_single});
      st(2'h2, 1'h1);
      link(6'h01, 1'h1, 1'h0);
      st(2'h0, 1'h0);
      $display("test single done");
   endtask
   task automatic complete_run;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      i_core_clk = 1'h0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   initial
   begin
      {i_reset, i_adv_pause, pan} = 3'h7;
      {i_ctl_we, i_led_mode_data, i_led_mode_we, i_remote_lb_en} = 4'h0;
      {cn, p100, burst} = 3'h0;
      i_ctl_data = 16'h1140;
      i_adv_ab = 6'h3F;
      pab = 6'h00;
      repeat (2) @(posedge i_core_clk);
      i_reset <= 1'h0;
      @(negedge i_core_clk);
      chk("reset speed", 8'h03, {6'h0, o_speed});
      chk("reset leds", 8'h03,
         {6'h0, o_link_indicator_out_n, o_activity_indicator_out_n});
      t_resolve;
      t_parallel;
      t_forced;
      t_restart;
      t_loop(6'h3F, 16'h1340, 2'h2);
      t_loop(6'h0C, 16'h3300, 2'h1);
      t_loop(6'h03, 16'h3300, 2'h0);
      t_single;
      complete_run;
   end
   // whole run needs a few hundred cycles
   initial
   begin
      repeat (20000) @(posedge i_core_clk);
      n_errors++;
      complete_run;
   end
endmodule
